//--- design/swm_consts.svh
/*
 Constants of the single-wire monitor link: opcodes, vectors, bit counts, register map.
 Assumes a 100 MHz system clock and inclusion by its bare name.
*/
// Contract
// - Host serial pin is wired-OR with pullup; either side only pulls it low.
// - Monitor touches only the host serial pin; host code in RAM may run.
// - Monitor entry by software interrupt or reset pin release with mode pins set.
// - After reset take eight security bytes, then send a ten-bit low break.
// - Monitor vectors live in the FE page: reset FEFE, break and trap FEFC.
// - Watchdog off in monitor with high test voltage; otherwise its disable bit rules.
// - Bypass pin low at entry skips the oscillator divide-by-two.
// - NRZ framing, same rate both ways, up to 28.8 kBaud.
// - Every received byte is echoed straight back on the host pin.
// - Command results follow the echo of the last command byte.
// - Start plus nine low bits is a break: release two bits, then echo it.
// - Six commands: read, write, indexed read, indexed write, stack read, run.
// - Indexed commands continue from the last accessed address, whole 64 KB.
// - Read is 4A, address high then low, echoes then the data byte.
// - Indexed read 1A echoes, then returns the next two bytes.
// - Stack read 0C echoes, then returns stack pointer high then low.
// - First variant, 4.9152 MHz: 4800 baud with bypass pin high, 9600 low.
// - With the PLL driving, rate is 4800 times the upper multiplier field; the code does this for fields 2 to 6 only, other values give 4800.
// - Second variant: rate scales with clock; bypass pin high halves it.
// - Security byte mismatch hides protected reads and blocks protected runs.
// - Passed security holds until power-on reset, despite later resets.
`ifndef SWM_CONSTS_SVH
`define SWM_CONSTS_SVH

`define SWM_CLK_HZ       100000000
`define SWM_BAUD_A       4800
`define SWM_BAUD_B_MILLI 7246370

`define SWM_OP_MEMRD 8'h4A
`define SWM_OP_MEMWR 8'h51
`define SWM_OP_IDXRD 8'h1A
`define SWM_OP_IDXWR 8'h52
`define SWM_OP_SPRD  8'h0C
`define SWM_OP_RUN   8'h53

`define SWM_VEC_RST_MON 16'hFEFE
`define SWM_VEC_RST_USR 16'hFFFE
`define SWM_VEC_BRK_MON 16'hFEFC
`define SWM_VEC_BRK_USR 16'hFFFC

`define SWM_SEC_LAST  3'h7
`define SWM_RX_BITS   4'h9
`define SWM_TX_BITS   4'hA
`define SWM_RDY_BITS  4'hA
`define SWM_BRK_BITS  4'hC
`define SWM_BRK_PAT   12'h003
`define SWM_UNDEF     8'h00
`define SWM_PROT_LO   16'h8000
`define SWM_PROT_HI   16'hFFFF

`define SWM_REG_CTRL  4'h0
`define SWM_REG_STAT  4'h4
`define SWM_REG_ADDR  4'h8
`define SWM_OKAY      2'h0
`define SWM_SLVERR    2'h2
`define SWM_CTRL_OVR  0
`define SWM_CTRL_DIVL 23:16
`define SWM_CTRL_DIVH 31:24

`endif

//--- design/swm_pkg.sv
/*
 Types of the single-wire monitor link: line and command states, the state record.
 Assumes swm_consts.svh for all numeric constants.
*/
package swm_pkg;
	typedef enum logic [2:0] {L_IDLE, L_RXHALF, L_RXBITS, L_TX, L_MEM} swm_line_t;
	typedef enum logic [2:0] {S_SEC, S_RDY, S_OP, S_AH, S_AL, S_DATA} swm_stage_t;
	typedef struct packed {
		swm_line_t  line;
		swm_stage_t stage;
		logic [15:0] tmr;
		logic [3:0]  bitCnt;
		logic [8:0]  rxSh;
		logic [11:0] txSh;
		logic        drvLow;
		logic [2:0]  secIdx;
		logic        secBad;
		logic        unlocked;
		logic        monitor;
		logic        bypass;
		logic        rstPrev;
		logic [7:0]  op;
		logic [7:0]  addrHi;
		logic [15:0] lastAddr;
		logic [15:0] resp;
		logic [1:0]  respCnt;
		logic [1:0]  memLeft;
		logic [15:0] memAddr;
		logic [7:0]  memWdata;
		logic        memWe;
		logic        memRe;
		logic        runReq;
		logic        illegalRst;
		logic        awHave;
		logic        wHave;
		logic [3:0]  awAddr;
		logic [31:0] wData;
		logic [3:0]  wStrb;
		logic        bValid;
		logic [1:0]  bResp;
		logic        rValid;
		logic [31:0] rData;
		logic [1:0]  rResp;
		logic        ovr;
		logic [15:0] divReg;
	} swm_state_t;
endpackage : swm_pkg

//--- design/swm_link.sv
/*
 Monitor-mode single-wire link: mode entry, vector page, watchdog gating,
 serial framing with echo and break, the six monitor commands, AXI4-Lite registers.
 Assumes all inputs synchronous to clock and a memory that answers memRe in the same cycle.
*/
`include "swm_consts.svh"

module swm_link #(
	parameter int          BIT_DIV_A = `SWM_CLK_HZ / `SWM_BAUD_A,
	parameter int          BIT_DIV_B = int'((64'(`SWM_CLK_HZ) * 64'd1000) / 64'(`SWM_BAUD_B_MILLI)),
	parameter bit          VARIANT_B = 1'b0,
	parameter logic [15:0] PROT_LO   = `SWM_PROT_LO,
	parameter logic [15:0] PROT_HI   = `SWM_PROT_HI
) (
	input  logic        clock,              // 100 MHz system clock
	input  logic        arst_n,             // Power-on reset, async, active low
	input  logic [3:0]  s_axi_awaddr,       // Write address
	input  logic        s_axi_awvalid,      // Write address valid
	output logic        s_axi_awready,      // Write address ready
	input  logic [31:0] s_axi_wdata,        // Write data
	input  logic [3:0]  s_axi_wstrb,        // Write byte strobes
	input  logic        s_axi_wvalid,       // Write data valid
	output logic        s_axi_wready,       // Write data ready
	output logic [1:0]  s_axi_bresp,        // Write response
	output logic        s_axi_bvalid,       // Write response valid
	input  logic        s_axi_bready,       // Write response ready
	input  logic [3:0]  s_axi_araddr,       // Read address
	input  logic        s_axi_arvalid,      // Read address valid
	output logic        s_axi_arready,      // Read address ready
	output logic [31:0] s_axi_rdata,        // Read data
	output logic [1:0]  s_axi_rresp,        // Read response
	output logic        s_axi_rvalid,       // Read data valid
	input  logic        s_axi_rready,       // Read data ready
	input  logic        hostSerialIn,       // Level of the host serial pin
	output logic        hostSerialOut,      // Value driven, always low
	output logic        hostSerialOe_n,     // Low while pulling the pin low
	input  logic        rstPin,             // Reset pin level, low in reset
	input  logic        highVoltage,        // Test voltage on interrupt or reset pin
	input  logic        modeSelA,           // Mode select pin a
	input  logic        modeSelB,           // Mode select pin b
	input  logic        dividerBypassPin,   // Divider bypass pin
	input  logic        softIntExec,        // Software interrupt executed, pulse
	input  logic        pllActive,          // PLL drives the clock generator output
	input  logic [3:0]  pllMulUpper,        // Upper PLL multiplier field
	input  logic        watchdogDisableBit, // Configuration disable of watchdog
	input  logic [63:0] securityBytes,      // Stored security bytes, first in low byte
	input  logic [15:0] stackPointer,       // CPU stack pointer
	output logic        monitorMode,        // Monitor mode active
	output logic        clkBypass,          // Skip oscillator divide-by-two
	output logic        watchdogEn,         // Watchdog enable
	output logic [15:0] vecReset,           // Reset vector address
	output logic [15:0] vecBreak,           // Break and trap vector address
	output logic        unlocked,           // Security passed
	output logic [15:0] memAddr,            // Memory address
	output logic [7:0]  memWdata,           // Memory write data
	output logic        memWe,              // Memory write strobe, pulse
	output logic        memRe,              // Memory read strobe, pulse
	input  logic [7:0]  memRdata,           // Memory read data, same cycle as memRe
	output logic        runReq,             // Start user program, pulse
	output logic [15:0] runAddr,            // Start address of user program
	output logic        illegalRst          // Illegal address reset, pulse
);
	import swm_pkg::*;

	swm_state_t  st_r;
	swm_state_t  st_nxt;
	logic [15:0] bitDiv;
	logic [8:0]  rxNext;
	logic [7:0]  rxByte;
	logic [7:0]  rdByte;
	logic [15:0] nextAddr;
	logic        tmrZero;
	logic        rxDone;
	logic        isBreak;
	logic        txDone;

	function automatic logic isProt(input logic [15:0] a);
		isProt = (a >= PROT_LO) && (a <= PROT_HI);
	endfunction : isProt

	// Rate select; software override wins so odd crystals can still be served
	always_comb begin
		bitDiv = 16'(BIT_DIV_A);
		if (st_r.ovr) begin
			bitDiv = st_r.divReg;
		end else if (VARIANT_B) begin
			bitDiv = st_r.bypass ? 16'(BIT_DIV_B) : 16'(BIT_DIV_B * 2);
		end else if (pllActive) begin
			case (pllMulUpper)
				4'h2: bitDiv = 16'(BIT_DIV_A / 2);
				4'h3: bitDiv = 16'(BIT_DIV_A / 3);
				4'h4: bitDiv = 16'(BIT_DIV_A / 4);
				4'h5: bitDiv = 16'(BIT_DIV_A / 5);
				4'h6: bitDiv = 16'(BIT_DIV_A / 6);
				default: bitDiv = 16'(BIT_DIV_A);
			endcase
		end else if (st_r.bypass) begin
			bitDiv = 16'(BIT_DIV_A / 2);
		end
	end

	assign tmrZero  = st_r.tmr == 16'h0000;
	assign rxNext   = {hostSerialIn, st_r.rxSh[8:1]};
	assign rxByte   = rxNext[7:0];
	assign rxDone   = st_r.line == L_RXBITS && tmrZero && st_r.bitCnt == 4'h1;
	assign isBreak  = rxDone && !rxNext[8] && rxByte == 8'h00;
	assign txDone   = st_r.line == L_TX && tmrZero && st_r.bitCnt == 4'h1;
	assign nextAddr = st_r.lastAddr + 16'h0001;
	// Locked reads of protected space never show the array
	assign rdByte   = (!st_r.unlocked && isProt(st_r.memAddr)) ? `SWM_UNDEF : memRdata;

	always_comb begin
		st_nxt = st_r;
		st_nxt.memWe = 1'b0;
		st_nxt.runReq = 1'b0;
		st_nxt.illegalRst = 1'b0;
		st_nxt.rstPrev = rstPin;
		st_nxt.tmr = tmrZero ? st_r.tmr : st_r.tmr - 16'h0001;

		if (rstPin && !st_r.rstPrev) begin
			st_nxt.monitor = highVoltage && modeSelA && !modeSelB && hostSerialIn;
			st_nxt.bypass = !dividerBypassPin;
		end else if (softIntExec) begin
			st_nxt.monitor = 1'b1;
		end

		if (!rstPin || !st_r.monitor) begin
			// Reset pin low or user mode restarts the security exchange but keeps the unlock
			st_nxt.line = L_IDLE;
			st_nxt.stage = S_SEC;
			st_nxt.secIdx = 3'h0;
			st_nxt.secBad = 1'b0;
			st_nxt.memRe = 1'b0;
			st_nxt.memLeft = 2'h0;
			st_nxt.respCnt = 2'h0;
		end else begin
			unique case (st_r.line)
				L_IDLE: begin
					if (!hostSerialIn) begin
						st_nxt.line = L_RXHALF;
						st_nxt.tmr = bitDiv >> 1;
					end
				end
				L_RXHALF: begin
					if (tmrZero) begin
						// A start bit gone by mid-bit was a glitch
						if (hostSerialIn) begin
							st_nxt.line = L_IDLE;
						end else begin
							st_nxt.line = L_RXBITS;
							st_nxt.tmr = bitDiv - 16'h0001;
							st_nxt.bitCnt = `SWM_RX_BITS;
						end
					end
				end
				L_RXBITS: begin
					if (tmrZero) begin
						st_nxt.rxSh = rxNext;
						st_nxt.bitCnt = st_r.bitCnt - 4'h1;
						st_nxt.tmr = bitDiv - 16'h0001;
						if (rxDone) begin
							st_nxt.line = L_TX;
							if (isBreak) begin
								st_nxt.txSh = `SWM_BRK_PAT;
								st_nxt.bitCnt = `SWM_BRK_BITS;
							end else begin
								st_nxt.txSh = {3'h7, rxByte, 1'b0};
								st_nxt.bitCnt = `SWM_TX_BITS;
								unique case (st_r.stage)
									S_SEC: begin
										if (rxByte != securityBytes[{st_r.secIdx, 3'h0} +: 8]) begin
											st_nxt.secBad = 1'b1;
										end
										st_nxt.secIdx = st_r.secIdx + 3'h1;
										if (st_r.secIdx == `SWM_SEC_LAST) begin
											st_nxt.stage = S_RDY;
											if (!st_nxt.secBad) begin
												st_nxt.unlocked = 1'b1;
											end
										end
									end
									S_RDY: begin
									end
									S_OP: begin
										st_nxt.op = rxByte;
										case (rxByte)
											`SWM_OP_MEMRD, `SWM_OP_MEMWR: st_nxt.stage = S_AH;
											`SWM_OP_IDXRD: st_nxt.memLeft = 2'h2;
											`SWM_OP_IDXWR: st_nxt.stage = S_DATA;
											`SWM_OP_SPRD: begin
												st_nxt.resp = stackPointer;
												st_nxt.respCnt = 2'h2;
											end
											`SWM_OP_RUN: begin
												// Host code may sit in RAM; only protected space is fenced
												if (!st_r.unlocked && isProt(st_r.lastAddr)) begin
													st_nxt.illegalRst = 1'b1;
												end else begin
													st_nxt.runReq = 1'b1;
												end
											end
											default: begin
											end
										endcase
									end
									S_AH: begin
										st_nxt.addrHi = rxByte;
										st_nxt.stage = S_AL;
									end
									S_AL: begin
										st_nxt.lastAddr = {st_r.addrHi, rxByte};
										if (st_r.op == `SWM_OP_MEMRD) begin
											st_nxt.memLeft = 2'h1;
											st_nxt.stage = S_OP;
										end else begin
											st_nxt.stage = S_DATA;
										end
									end
									S_DATA: begin
										st_nxt.memWe = 1'b1;
										st_nxt.memWdata = rxByte;
										if (st_r.op == `SWM_OP_IDXWR) begin
											st_nxt.memAddr = nextAddr;
											st_nxt.lastAddr = nextAddr;
										end else begin
											st_nxt.memAddr = st_r.lastAddr;
										end
										st_nxt.stage = S_OP;
									end
									default: st_nxt.stage = S_OP;
								endcase
							end
						end
					end
				end
				L_TX: begin
					if (tmrZero) begin
						st_nxt.tmr = bitDiv - 16'h0001;
						if (st_r.bitCnt != 4'h1) begin
							st_nxt.txSh = st_r.txSh >> 1;
							st_nxt.bitCnt = st_r.bitCnt - 4'h1;
						end else if (st_r.stage == S_RDY) begin
							st_nxt.txSh = 12'h000;
							st_nxt.bitCnt = `SWM_RDY_BITS;
							st_nxt.stage = S_OP;
						end else if (st_r.respCnt != 2'h0) begin
							st_nxt.txSh = {3'h7, st_r.resp[15:8], 1'b0};
							st_nxt.bitCnt = `SWM_TX_BITS;
							st_nxt.resp = {st_r.resp[7:0], 8'h00};
							st_nxt.respCnt = st_r.respCnt - 2'h1;
						end else if (st_r.memLeft != 2'h0) begin
							st_nxt.line = L_MEM;
							st_nxt.memRe = 1'b1;
							if (st_r.op == `SWM_OP_IDXRD) begin
								st_nxt.memAddr = nextAddr;
								st_nxt.lastAddr = nextAddr;
							end else begin
								st_nxt.memAddr = st_r.lastAddr;
							end
						end else begin
							st_nxt.line = L_IDLE;
						end
					end
				end
				L_MEM: begin
					st_nxt.memRe = 1'b0;
					st_nxt.line = L_TX;
					st_nxt.tmr = bitDiv - 16'h0001;
					st_nxt.txSh = {3'h7, rdByte, 1'b0};
					st_nxt.bitCnt = `SWM_TX_BITS;
					st_nxt.memLeft = st_r.memLeft - 2'h1;
				end
				default: st_nxt.line = L_IDLE;
			endcase
		end
		// Only ever pull low; a one bit releases the wired-OR line
		st_nxt.drvLow = st_nxt.line == L_TX && !st_nxt.txSh[0];

		// Register slave
		if (s_axi_awvalid && s_axi_awready) begin
			st_nxt.awHave = 1'b1;
			st_nxt.awAddr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			st_nxt.wHave = 1'b1;
			st_nxt.wData = s_axi_wdata;
			st_nxt.wStrb = s_axi_wstrb;
		end
		if (st_r.awHave && st_r.wHave) begin
			st_nxt.awHave = 1'b0;
			st_nxt.wHave = 1'b0;
			st_nxt.bValid = 1'b1;
			st_nxt.bResp = `SWM_OKAY;
			case (st_r.awAddr)
				`SWM_REG_CTRL: begin
					if (st_r.wStrb[0]) st_nxt.ovr = st_r.wData[`SWM_CTRL_OVR];
					if (st_r.wStrb[2]) st_nxt.divReg[7:0] = st_r.wData[`SWM_CTRL_DIVL];
					if (st_r.wStrb[3]) st_nxt.divReg[15:8] = st_r.wData[`SWM_CTRL_DIVH];
				end
				`SWM_REG_STAT, `SWM_REG_ADDR: begin
				end
				default: st_nxt.bResp = `SWM_SLVERR;
			endcase
		end
		if (st_r.bValid && s_axi_bready) st_nxt.bValid = 1'b0;
		if (s_axi_arvalid && s_axi_arready) begin
			st_nxt.rValid = 1'b1;
			st_nxt.rResp = `SWM_OKAY;
			case (s_axi_araddr)
				`SWM_REG_CTRL: st_nxt.rData = {st_r.divReg, 15'h0000, st_r.ovr};
				`SWM_REG_STAT: st_nxt.rData = {21'h00_0000, st_r.line, 1'b0, st_r.stage,
					st_r.bypass, st_r.secBad, st_r.unlocked, st_r.monitor};
				`SWM_REG_ADDR: st_nxt.rData = {16'h0000, st_r.lastAddr};
				default: begin
					st_nxt.rData = 32'h0000_0000;
					st_nxt.rResp = `SWM_SLVERR;
				end
			endcase
		end
		if (st_r.rValid && s_axi_rready) st_nxt.rValid = 1'b0;
	end

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			st_r <= '0;
			st_r.divReg <= 16'(BIT_DIV_A);
		end else begin
			st_r <= st_nxt;
		end
	end

	assign s_axi_awready  = !st_r.awHave && !st_r.bValid;
	assign s_axi_wready   = !st_r.wHave && !st_r.bValid;
	assign s_axi_bvalid   = st_r.bValid;
	assign s_axi_bresp    = st_r.bResp;
	assign s_axi_arready  = !st_r.rValid;
	assign s_axi_rvalid   = st_r.rValid;
	assign s_axi_rdata    = st_r.rData;
	assign s_axi_rresp    = st_r.rResp;
	assign hostSerialOut  = 1'b0;
	assign hostSerialOe_n = !st_r.drvLow;
	assign monitorMode    = st_r.monitor;
	assign clkBypass      = st_r.monitor && st_r.bypass;
	assign watchdogEn     = !(st_r.monitor && highVoltage) && !watchdogDisableBit;
	assign vecReset       = st_r.monitor ? `SWM_VEC_RST_MON : `SWM_VEC_RST_USR;
	assign vecBreak       = st_r.monitor ? `SWM_VEC_BRK_MON : `SWM_VEC_BRK_USR;
	assign unlocked       = st_r.unlocked;
	assign memAddr        = st_r.memAddr;
	assign memWdata       = st_r.memWdata;
	assign memWe          = st_r.memWe;
	assign memRe          = st_r.memRe;
	assign runReq         = st_r.runReq;
	assign runAddr        = st_r.lastAddr;
	assign illegalRst     = st_r.illegalRst;

	default clocking cb @(posedge clock); endclocking
	default disable iff (!arst_n);

	sequence byteIn;
		rxDone && !isBreak;
	endsequence
	sequence releaseHeld;
		(!st_r.drvLow)[*8];
	endsequence

	echo_byte_a: assert property (byteIn |=> st_r.line == L_TX && st_r.drvLow
		&& st_r.txSh[8:1] == $past(rxByte)) else $error("received byte not echoed");
	break_reply_a: assert property (isBreak |=> st_r.txSh == `SWM_BRK_PAT ##0 releaseHeld)
		else $error("break not answered by release");
	pin_drive_a: assert property (!hostSerialOe_n |-> st_r.line == L_TX)
		else $error("pin pulled outside transmit");
	vec_page_a: assert property (st_r.monitor |-> vecReset == `SWM_VEC_RST_MON
		&& vecBreak == `SWM_VEC_BRK_MON) else $error("wrong vector page");
	wdog_off_a: assert property (st_r.monitor && highVoltage |-> !watchdogEn)
		else $error("watchdog enabled under test voltage");
	ready_break_a: assert property (txDone && st_r.stage == S_RDY |=> st_r.txSh == 12'h000
		&& st_r.bitCnt == `SWM_RDY_BITS && st_r.stage == S_OP) else $error("no ready break");
	lock_hold_a: assert property ($past(st_r.unlocked) |-> st_r.unlocked)
		else $error("unlock lost without power-on reset");
	resp_order_a: assert property ($rose(st_r.memRe) |-> $past(st_r.line) == L_TX)
		else $error("read result before echo ended");
	rate_pick_a: assert property (!VARIANT_B && !st_r.ovr && !pllActive |->
		bitDiv == (st_r.bypass ? 16'(BIT_DIV_A / 2) : 16'(BIT_DIV_A))) else $error("bad bit rate");
	sp_load_a: assert property (byteIn and (st_r.stage == S_OP && rxByte == `SWM_OP_SPRD) |=>
		st_r.respCnt == 2'h2 && st_r.resp == $past(stackPointer)) else $error("stack pointer not queued");
endmodule : swm_link

//--- tb/swm_host_model.sv
/*
 Host-side model of the single-wire monitor link: sends frames on the shared pin.
 Assumes the bench resolves the wired-OR pin and calls sendFrame right after a clock edge.
*/
module swm_host_model #(
	parameter int D = 16
) (
	input  wire logic clock,    // System clock
	input  wire logic pinLevel, // Resolved level of the shared pin
	output logic      pullLow   // High while the host pulls the pin low
);
	timeunit 1ns;
	timeprecision 100ps;

	// Released at rest, so the pullup sets the idle level
	initial pullLow = 1'b0;

	// Start bit, then nine payload bits; a break is all zero so its stop stays low
	task automatic sendFrame(input logic [8:0] f);
		logic [9:0] bits;
		bits = {f, 1'b0};
		while (!pinLevel) @(posedge clock);
		for (int k = 0; k < 10; k++) begin
			pullLow <= !bits[k];
			repeat (D) @(posedge clock);
		end
		pullLow <= 1'b0;
	endtask : sendFrame
endmodule : swm_host_model

//--- tb/single_wire_monitor_link_tb_top.sv
/*
 Self-checking bench of the single-wire monitor link: mode entry, security, commands, break, registers.
 Assumes swm_consts.svh, swm_link and swm_host_model; bit period forced short through BIT_DIV_A and, before the power-on reset, the divisor register.
*/
`include "swm_consts.svh"
`define CHK(n, e, g) begin totalChecks++; if ((g) !== (e)) begin miscompares++; \
	$display("unexpected %s expected %h seen %h", n, e, g); end end

module single_wire_monitor_link_tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	localparam int D = 16;
	logic        clock, arst_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [3:0]  s_axi_awaddr, s_axi_wstrb, s_axi_araddr, pllMulUpper;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	logic        hostSerialOut, hostSerialOe_n, rstPin, highVoltage, modeSelA, modeSelB, dividerBypassPin;
	logic        softIntExec, pllActive, watchdogDisableBit, monitorMode, clkBypass, watchdogEn, unlocked;
	logic        memWe, memRe, runReq, pullLow, runSeen, illegalRst, illSeen;
	logic [63:0] securityBytes;
	logic [15:0] stackPointer, vecReset, vecBreak, memAddr, runAddr, runAt, addrA;
	logic [7:0]  memWdata, wrA, wrB;
	logic [7:0]  mem [65536];
	logic [8:0]  expQ [$];
	int          miscompares = 0, totalChecks = 0, cycles = 0, seed = 25071;
	wire         pinLevel = (hostSerialOe_n | hostSerialOut) & !pullLow;
	wire  [7:0]  memRdata = mem[memAddr];

	swm_link #(.BIT_DIV_A(D)) dut (.clock, .arst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
		.s_axi_rready, .hostSerialIn(pinLevel), .hostSerialOut, .hostSerialOe_n, .rstPin, .highVoltage,
		.modeSelA, .modeSelB, .dividerBypassPin, .softIntExec, .pllActive, .pllMulUpper, .watchdogDisableBit,
		.securityBytes, .stackPointer, .monitorMode, .clkBypass, .watchdogEn, .vecReset, .vecBreak, .unlocked,
		.memAddr, .memWdata, .memWe, .memRe, .memRdata, .runReq, .runAddr, .illegalRst);
	swm_host_model #(.D(D)) host (.clock, .pinLevel, .pullLow);

	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end

	function automatic logic [7:0] memInit(input logic [15:0] a);
		return a[7:0] ^ 8'h3C;
	endfunction : memInit

	task automatic finishTest;
		if (miscompares == 0 && totalChecks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : finishTest

	// Memory model, run capture and hang guard
	always @(posedge clock) begin
		cycles++;
		if (memWe) mem[memAddr] <= memWdata;
		if (runReq) begin
			runSeen <= 1'b1;
			runAt   <= runAddr;
		end
		if (illegalRst) illSeen <= 1'b1;
		if (cycles == 60000) begin
			miscompares++;
			finishTest();
		end
	end

	// Decodes every frame the device drives and checks it against the oldest note
	initial begin : watcher
		logic [9:0] bits;
		logic [8:0] e9;
		forever begin
			@(negedge hostSerialOe_n);
			repeat (D / 2) @(posedge clock);
			for (int k = 0; k < 10; k++) begin
				bits[k] = pinLevel;
				if (k < 9) repeat (D) @(posedge clock);
			end
			e9 = (expQ.size() != 0) ? expQ.pop_front() : 9'h1FF;
			`CHK("frame", e9, bits[9:1])
		end
	end

	task automatic drain;
		while (expQ.size() != 0) @(posedge clock);
		repeat (2 * D) @(posedge clock);
	endtask : drain

	// Negative count means the ready break follows the echo
	task automatic tx(input logic [7:0] b, input int n = 0, input logic [7:0] r0 = 8'h00, r1 = 8'h00);
		expQ.push_back({1'b1, b});
		if (n < 0) expQ.push_back(9'h000);
		if (n > 0) expQ.push_back({1'b1, r0});
		if (n > 1) expQ.push_back({1'b1, r1});
		host.sendFrame({1'b1, b});
		drain();
	endtask : tx

	task automatic cmd3(input logic [7:0] op, input logic [15:0] a, input int n, input logic [7:0] r0);
		tx(op);
		tx(a[15:8]);
		tx(a[7:0], n, r0);
	endtask : cmd3

	task automatic axiWr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
		logic aT, wT, b;
		logic [1:0] r;
		@(posedge clock);
		s_axi_awaddr  <= a;
		s_axi_wdata   <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid  <= 1'b1;
		s_axi_bready  <= 1'b1;
		do begin
			@(negedge clock);
			aT = s_axi_awvalid & s_axi_awready;
			wT = s_axi_wvalid & s_axi_wready;
			b  = s_axi_bvalid;
			r  = s_axi_bresp;
			@(posedge clock);
			if (aT) s_axi_awvalid <= 1'b0;
			if (wT) s_axi_wvalid <= 1'b0;
		end while (!b);
		s_axi_bready <= 1'b0;
		`CHK("bresp", er, r)
	endtask : axiWr

	task automatic axiRd(input logic [3:0] a, input logic [31:0] ed, input logic [1:0] er);
		logic aT, v;
		logic [31:0] d;
		logic [1:0] r;
		@(posedge clock);
		s_axi_araddr  <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready  <= 1'b1;
		do begin
			@(negedge clock);
			aT = s_axi_arvalid & s_axi_arready;
			v  = s_axi_rvalid;
			d  = s_axi_rdata;
			r  = s_axi_rresp;
			@(posedge clock);
			if (aT) s_axi_arvalid <= 1'b0;
		end while (!v);
		s_axi_rready <= 1'b0;
		`CHK("rdata", ed, d)
		`CHK("rresp", er, r)
	endtask : axiRd

	initial begin : main
		logic [15:0] a5;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = {40'h00_0000_0000, 4'hF};
		{modeSelB, softIntExec, pllActive, dividerBypassPin, runSeen, illSeen, arst_n} = 7'h00;
		{rstPin, highVoltage, modeSelA} = 3'h7;
		pllMulUpper = 4'h1;
		runAt = 16'h0000;
		securityBytes = {$random(seed), $random(seed)};
		stackPointer = 16'($random(seed));
		watchdogDisableBit = 1'($random(seed));
		addrA = {2'h0, 14'($random(seed))};
		wrA = 8'($random(seed));
		wrB = 8'($random(seed));
		a5 = addrA + 16'h0005;
		for (int i = 0; i < 65536; i++) mem[i] = memInit(16'(i));
		repeat (20) @(posedge clock);
		arst_n <= 1'b1;
		repeat (3) @(posedge clock);
		`CHK("monitorMode", 1'b1, monitorMode)
		`CHK("clkBypass", 1'b1, clkBypass)
		`CHK("vecReset", `SWM_VEC_RST_MON, vecReset)
		`CHK("vecBreak", `SWM_VEC_BRK_MON, vecBreak)
		`CHK("watchdogEn", 1'b0, watchdogEn)
		highVoltage <= 1'b0;
		repeat (2) @(posedge clock);
		`CHK("watchdogEn", !watchdogDisableBit, watchdogEn)
		highVoltage <= 1'b1;
		axiWr(`SWM_REG_CTRL, {16'(D), 16'h0001}, `SWM_OKAY);
		axiWr(`SWM_REG_ADDR, 32'hFFFF_FFFF, `SWM_OKAY);
		axiRd(`SWM_REG_CTRL, {16'(D), 16'h0001}, `SWM_OKAY);
		axiRd(4'hC, 32'h0000_0000, `SWM_SLVERR);
		for (int i = 0; i < 8; i++) tx(securityBytes[8 * i +: 8], (i == 7) ? -1 : 0);
		`CHK("unlocked", 1'b1, unlocked)
		cmd3(`SWM_OP_MEMWR, addrA, 0, 8'h00);
		tx(wrA);
		cmd3(`SWM_OP_MEMRD, addrA, 1, wrA);
		tx(`SWM_OP_IDXRD, 2, memInit(addrA + 16'h0001), memInit(addrA + 16'h0002));
		tx(`SWM_OP_IDXRD, 2, memInit(addrA + 16'h0003), memInit(addrA + 16'h0004));
		tx(`SWM_OP_IDXWR);
		tx(wrB);
		cmd3(`SWM_OP_MEMRD, a5, 1, wrB);
		tx(`SWM_OP_SPRD, 2, stackPointer[15:8], stackPointer[7:0]);
		tx(`SWM_OP_RUN);
		`CHK("runSeen", 1'b1, runSeen)
		`CHK("runAddr", a5, runAt)
		axiRd(`SWM_REG_ADDR, {16'h0000, a5}, `SWM_OKAY);
		expQ.push_back(9'h000);
		host.sendFrame(9'h000);
		drain();
		dividerBypassPin <= 1'b1;
		rstPin <= 1'b0;
		repeat (4) @(posedge clock);
		rstPin <= 1'b1;
		repeat (3) @(posedge clock);
		`CHK("clkBypass", 1'b0, clkBypass)
		for (int i = 0; i < 8; i++) tx(~securityBytes[8 * i +: 8], (i == 7) ? -1 : 0);
		`CHK("unlocked", 1'b1, unlocked)
		cmd3(`SWM_OP_MEMRD, addrA | 16'h8000, 1, memInit(addrA | 16'h8000));
		// Power-on reset relocks; entry pins off so only the trap can enter monitor
		arst_n <= 1'b0;
		modeSelA <= 1'b0;
		repeat (3) @(posedge clock);
		arst_n <= 1'b1;
		repeat (3) @(posedge clock);
		`CHK("monitorMode", 1'b0, monitorMode)
		`CHK("vecReset", `SWM_VEC_RST_USR, vecReset)
		`CHK("unlocked", 1'b0, unlocked)
		softIntExec <= 1'b1;
		@(posedge clock);
		softIntExec <= 1'b0;
		modeSelA <= 1'b1;
		repeat (2) @(posedge clock);
		`CHK("monitorMode", 1'b1, monitorMode)
		for (int i = 0; i < 8; i++) tx(~securityBytes[8 * i +: 8], (i == 7) ? -1 : 0);
		`CHK("unlocked", 1'b0, unlocked)
		cmd3(`SWM_OP_MEMRD, addrA | 16'h8000, 1, `SWM_UNDEF);
		runSeen <= 1'b0;
		tx(`SWM_OP_RUN);
		`CHK("illegalRst", 1'b1, illSeen)
		`CHK("runSeen", 1'b0, runSeen)
		axiRd(`SWM_REG_STAT, 32'h0000_0025, `SWM_OKAY);
		finishTest();
	end
endmodule : single_wire_monitor_link_tb_top
